// ### design/sensor_sample_fifo_readout.sv
// Register-side readout of the sensor: temperature change, part id,
// 32-sample queue with status and byte-serial data port.
// Assumes the serial target logic presents byte reads on regRead/regAddr
// in the same clock domain, and that setup bits come from their own register.
//
// Summary of operation
// - Temperature change held as 12-bit signed, whole degrees in high byte.
// - Fraction sits in bits 7..4 of low byte; bits 3..0 reserved.
// - Temperature change updates whatever the queue mode.
// - Identifier register returns a fixed factory value; writes cannot change it.
// - Status byte: overflow bit 7, threshold bit 6, count bits 5..0.
// - Overflow flag sets on a queue overflow event, else reads zero.
// - Threshold flag sets while count exceeds a nonzero programmed threshold; threshold zero keeps it clear.
// - Both flags hold while their cause persists; status reads do not clear them, a sample pop clears overflow.
// - Reading the status byte clears the queue interrupt source bit.
// - Queue holds 32 five-byte samples, 160 bytes through the data port.
// - With queue enabled, data port also answers at first pressure address.
// - With queue enabled, other pressure and temperature addresses read zero.
// - Samples keep entering the queue while the host reads data.
// - Bytes leave as pressure high, mid, low, temp high, low; empty reads zero.
// - Bytes come from the oldest sample; a finished sample pops and decrements count.
// - Mode 00 off, 01 circular overwrite, 10 stop when full, 11 unused.
// - Disabling or standby-to-active wake flushes queue, flags and count.
`include "sensor_fifo_map.svh"

module sensor_sample_fifo_readout
  import sensor_fifo_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5a // Arbitrary value, stands in for the programmed id
)(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register read port
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  output logic [7:0] regRdData,
  output logic queueIntClear,
  // Setup bits and mode events
  input wire queue_mode_t queueMode,
  input wire logic [5:0] queue_threshold,
  input wire logic wakeToActive,
  // Acquisition
  input wire logic sampleValid,
  input wire sample_t sampleIn,
  input wire logic tempChangeValid,
  input wire logic [11:0] temp_change_value,
  // Status view
  output logic queue_overrun_flag,
  output logic queue_threshold_flag,
  output logic [5:0] queue_sample_count
);

  localparam int DEPTH = `Q_DEPTH;
  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_reg, rstSync_reg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  wire rstN = rstSync_reg;

  // Byte n of a sample, in readout order
  function automatic logic [7:0] sampleByte(input sample_t s, input logic [2:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      3'h0: b = s.pHigh;
      3'h1: b = s.pressure_out_mid;
      3'h2: b = s.pLow;
      3'h3: b = s.tHigh;
      3'h4: b = s.tLow;
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  sample_t mem [DEPTH];
  sample_t live_reg;
  logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [5:0] count_reg, count_next;
  logic [2:0] byteIdx_reg, byteIdx_next;
  logic ovf_reg, ovf_next, thr_reg, thr_next;
  logic [11:0] tChg_reg;
  logic [7:0] rdData_reg;
  logic intClr_reg;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire queueOn = (queueMode == QMODE_CIRC) || (queueMode == QMODE_STOP);
  // Mode 11 is treated as off so the queue never runs in an undefined mode
  wire flush = !queueOn || wakeToActive;
  wire dataAddr = (regAddr == `ADDR_Q_DATA) || (queueOn && regAddr == `ADDR_P_HIGH);
  wire dataRead = regRead && dataAddr;
  wire haveData = count_reg != 6'h00;
  wire full = count_reg == 6'(DEPTH);
  wire lastByte = byteIdx_reg == `SAMPLE_BYTES - 3'h1;
  wire popNow = dataRead && haveData && lastByte && !flush;
  wire pushNow = sampleValid && !flush;
  wire circ = queueMode == QMODE_CIRC;
  // Pop in the same cycle frees a slot, so a full queue takes the sample
  wire writeNow = pushNow && (!full || circ || popNow);
  wire dropOld = pushNow && full && circ && !popNow;
  wire ovfEvent = pushNow && full && !popNow;
  wire liveAddr = regAddr >= `ADDR_P_HIGH && regAddr <= `ADDR_T_LOW;
  wire statusRead = regRead && regAddr == `ADDR_Q_STATUS;
  wire [7:0] statusByte = {ovf_reg, thr_reg, count_reg};
  wire [7:0] queueByte = haveData ? sampleByte(mem[rdPtr_reg], byteIdx_reg) : 8'h00;
  wire [7:0] liveByte = sampleByte(live_reg, 3'(regAddr - `ADDR_P_HIGH));
  wire [7:0] tChgHigh = tChg_reg[11:4];
  wire [7:0] tChgLow = {tChg_reg[3:0], `TCHG_RSVD_BITS};
  wire [7:0] rdMux;

  // Address decode for reads
  assign rdMux = dataAddr ? queueByte :
    (queueOn && liveAddr) ? 8'h00 :
    liveAddr ? liveByte :
    (regAddr == `ADDR_TCHG_HIGH) ? tChgHigh :
    (regAddr == `ADDR_TCHG_LOW) ? tChgLow :
    (regAddr == `ADDR_PART_ID) ? PART_ID :
    (regAddr == `ADDR_Q_STATUS) ? statusByte :
    8'h00;

  // ----------------------------------------
  // Queue next state
  // ----------------------------------------
  always_comb begin
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    byteIdx_next = byteIdx_reg;
    ovf_next = ovf_reg;
    if (flush) begin
      wrPtr_next = '0;
      rdPtr_next = '0;
      count_next = 6'h00;
      byteIdx_next = 3'h0;
      ovf_next = 1'b0;
    end else begin
      if (writeNow) begin
        wrPtr_next = wrPtr_reg + PW'(1);
      end
      if (popNow || dropOld) begin
        rdPtr_next = rdPtr_reg + PW'(1);
      end
      count_next = count_reg + 6'(writeNow && !dropOld) - 6'(popNow);
      // An overwritten front sample restarts its byte sequence
      if (dropOld || popNow) begin
        byteIdx_next = 3'h0;
      end else if (dataRead && haveData) begin
        byteIdx_next = byteIdx_reg + 3'h1;
      end
      // A pop clears overflow, even with a push into the full queue that cycle; otherwise it persists while the queue stays full
      if (ovfEvent) begin
        ovf_next = 1'b1;
      end else if (popNow) begin
        ovf_next = 1'b0;
      end
    end
    thr_next = !flush && queue_threshold != 6'h00 && count_next > queue_threshold;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= 6'h00;
      byteIdx_reg <= 3'h0;
      ovf_reg <= 1'b0;
      thr_reg <= 1'b0;
      rdData_reg <= `REG_RESET;
      intClr_reg <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      byteIdx_reg <= byteIdx_next;
      ovf_reg <= ovf_next;
      thr_reg <= thr_next;
      rdData_reg <= regRead ? rdMux : rdData_reg;
      intClr_reg <= statusRead;
    end
  end

  // Temperature change and live sample keep updating in every mode
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      tChg_reg <= 12'h000;
      live_reg <= '0;
    end else begin
      tChg_reg <= tempChangeValid ? temp_change_value : tChg_reg;
      live_reg <= sampleValid ? sampleIn : live_reg;
    end
  end

  // Storage carries no reset; count and pointers define what is valid
  always_ff @(posedge clock) begin
    if (writeNow) begin
      mem[wrPtr_reg] <= sampleIn;
    end
  end

  assign regRdData = rdData_reg;
  assign queueIntClear = intClr_reg;
  assign queue_overrun_flag = ovf_reg;
  assign queue_threshold_flag = thr_reg;
  assign queue_sample_count = count_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_tchgLow;
    @(posedge clock) disable iff (!rstN)
    regRead && regAddr == `ADDR_TCHG_LOW |=> regRdData[3:0] == 4'h0 && regRdData[7:4] == $past(tChg_reg[3:0]);
  endproperty
  a_tchgLow: assert property (p_tchgLow) else $error("temp change low byte wrong");
  property p_tchgHigh;
    @(posedge clock) disable iff (!rstN)
    // One idle cycle between latch and read, as a host sees it after the update
    tempChangeValid ##1 !tempChangeValid ##1 (regRead && regAddr == `ADDR_TCHG_HIGH && !tempChangeValid)
      |=> regRdData == $past(temp_change_value[11:4], 3);
  endproperty
  a_tchgHigh: assert property (p_tchgHigh) else $error("temp change high byte wrong");
  property p_partId;
    @(posedge clock) disable iff (!rstN)
    regRead && regAddr == `ADDR_PART_ID |=> regRdData == PART_ID;
  endproperty
  a_partId: assert property (p_partId) else $error("part id wrong");
  property p_status;
    @(posedge clock) disable iff (!rstN)
    statusRead |=> regRdData == {$past(ovf_reg), $past(thr_reg), $past(count_reg)} && queueIntClear;
  endproperty
  a_status: assert property (p_status) else $error("status byte or clear wrong");
  property p_ovfSet;
    @(posedge clock) disable iff (!rstN)
    ovfEvent && !flush ##1 !flush && !popNow |=> queue_overrun_flag;
  endproperty
  a_ovfSet: assert property (p_ovfSet) else $error("overflow flag lost");
  property p_thr;
    @(posedge clock) disable iff (!rstN)
    !flush |=> queue_threshold_flag == ($past(queue_threshold) != 6'h00 && count_reg > $past(queue_threshold));
  endproperty
  a_thr: assert property (p_thr) else $error("threshold flag wrong");
  property p_depth;
    @(posedge clock) disable iff (!rstN)
    count_reg <= 6'(DEPTH);
  endproperty
  a_depth: assert property (p_depth) else $error("count above depth");
  property p_alias;
    @(posedge clock) disable iff (!rstN)
    regRead && queueOn && regAddr > `ADDR_P_HIGH && regAddr <= `ADDR_T_LOW |=> regRdData == 8'h00;
  endproperty
  a_alias: assert property (p_alias) else $error("live byte seen while queue on");
  property p_empty;
    @(posedge clock) disable iff (!rstN)
    dataRead && !haveData |=> regRdData == 8'h00;
  endproperty
  a_empty: assert property (p_empty) else $error("empty queue read not zero");
  property p_pop;
    @(posedge clock) disable iff (!rstN)
    popNow && !pushNow |=> count_reg == $past(count_reg) - 6'h01 && byteIdx_reg == 3'h0;
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not decrement");
  property p_acq;
    @(posedge clock) disable iff (!rstN)
    pushNow && dataRead && !full && !popNow |=> count_reg == $past(count_reg) + 6'h01;
  endproperty
  a_acq: assert property (p_acq) else $error("sample lost during read");
  property p_stop;
    @(posedge clock) disable iff (!rstN)
    pushNow && full && queueMode == QMODE_STOP && !popNow |=> rdPtr_reg == $past(rdPtr_reg) && count_reg == 6'(DEPTH);
  endproperty
  a_stop: assert property (p_stop) else $error("stop mode overwrote");
  property p_flush;
    @(posedge clock) disable iff (!rstN)
    flush |=> count_reg == 6'h00 && !queue_overrun_flag && !queue_threshold_flag;
  endproperty
  a_flush: assert property (p_flush) else $error("flush incomplete");

  c_fullRead: cover property (@(posedge clock) disable iff (!rstN) full ##1 popNow);
  c_circ: cover property (@(posedge clock) disable iff (!rstN) dropOld);
  c_aliasRead: cover property (@(posedge clock) disable iff (!rstN) dataRead && regAddr == `ADDR_P_HIGH && haveData);
  c_thr: cover property (@(posedge clock) disable iff (!rstN) queue_threshold_flag && statusRead);

endmodule // sensor_sample_fifo_readout

// ### shared/sensor_fifo_map.svh
// Address map, field positions and constants of the sample queue readout.
// Assumes byte-wide register addresses as seen by the serial target port.
`ifndef SENSOR_FIFO_MAP_SVH
`define SENSOR_FIFO_MAP_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_P_HIGH 8'h01
`define ADDR_P_MID 8'h02
`define ADDR_P_LOW 8'h03
`define ADDR_T_HIGH 8'h04
`define ADDR_T_LOW 8'h05
`define ADDR_TCHG_HIGH 8'h0a
`define ADDR_TCHG_LOW 8'h0b
`define ADDR_PART_ID 8'h0c
`define ADDR_Q_STATUS 8'h0d
`define ADDR_Q_DATA 8'h0e

// ----------------------------------------
// Fields, reset values, sizes
// ----------------------------------------
`define STAT_OVF_BIT 7
`define STAT_THR_BIT 6
`define TCHG_RSVD_BITS 4'h0
`define REG_RESET 8'h00
`define Q_DEPTH 32
`define Q_CNT_W 6
`define SAMPLE_BYTES 3'h5
`define MODE_OFF 2'h0
`define MODE_CIRC 2'h1
`define MODE_STOP 2'h2

`endif

// ### shared/sensor_fifo_pkg.sv
// Types shared by the sample queue readout and its bench.
// Assumes nothing beyond the constant header.
package sensor_fifo_pkg;

  // One stored sample, in the order the bytes leave the data port
  typedef struct packed {
    logic [7:0] pHigh;
    logic [7:0] pressure_out_mid;
    logic [7:0] pLow;
    logic [7:0] tHigh;
    logic [7:0] tLow;
  } sample_t;

  typedef enum logic [1:0] {
    QMODE_OFF = 2'h0,
    QMODE_CIRC = 2'h1,
    QMODE_STOP = 2'h2,
    QMODE_UNUSED = 2'h3
  } queue_mode_t;

endpackage

// ### test/reg_host_model.sv
// Host side of the register read port: issues single byte reads.
// Assumes reads are taken on the rising edge and answered one cycle later.
module reg_host_model (
  // Clock
  input wire logic clock,
  // Read port towards the readout
  output logic regRead,
  output logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic queueIntClear
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    regRead = 1'b0;
    regAddr = 8'h00;
  end

  // ----------------------------------------
  // One read; the address is inverted once released so no stale value lingers
  // ----------------------------------------
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic c);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clock);
    d = regRdData;
    c = queueIntClear;
  endtask
endmodule // reg_host_model

// ### test/tb_sensor_sample_fifo_readout.sv
// Self-checking bench of the sample queue readout.
// Assumes the host model above and the shared package; one clock domain.
module tb_sensor_sample_fifo_readout;
  import sensor_fifo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ID = 8'h3b; // Arbitrary value for the identifier

  logic clock, arst_n, regRead, queueIntClear, wakeToActive, sampleValid, tempChangeValid;
  logic queue_overrun_flag, queue_threshold_flag;
  logic [7:0] regAddr, regRdData;
  logic [5:0] queue_threshold, queue_sample_count;
  logic [11:0] temp_change_value;
  queue_mode_t queueMode;
  sample_t sampleIn;
  int bad_count = 0;
  int cmp_count = 0;

  sensor_sample_fifo_readout #(.PART_ID(ID)) DUT (
    .clock(clock), .arst_n(arst_n), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
    .queueIntClear(queueIntClear), .queueMode(queueMode), .queue_threshold(queue_threshold),
    .wakeToActive(wakeToActive), .sampleValid(sampleValid), .sampleIn(sampleIn),
    .tempChangeValid(tempChangeValid), .temp_change_value(temp_change_value),
    .queue_overrun_flag(queue_overrun_flag), .queue_threshold_flag(queue_threshold_flag),
    .queue_sample_count(queue_sample_count)
  );

  reg_host_model host (
    .clock(clock), .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData),
    .queueIntClear(queueIntClear)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic sample_t mk(input logic [7:0] k);
    return {k, k ^ 8'h5a, ~k, k + 8'h40, k + 8'h80};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic c;
    host.read(a, d, c);
    chk(d, e);
  endtask

  // Status read also expects the one-cycle clear pulse
  task automatic rs(input logic [7:0] e);
    logic [7:0] d;
    logic c;
    host.read(8'h0d, d, c);
    chk(d, e);
    chk({queue_overrun_flag, queue_threshold_flag, queue_sample_count}, e);
    chk({7'h00, c}, 8'h01);
  endtask

  // Bytes i0..i1 of sample k through address a
  task automatic rdb(input logic [7:0] a, input logic [7:0] k, input int i0, input int i1);
    logic [39:0] s;
    s = mk(k);
    for (int i = i0; i <= i1; i++) begin
      rd(a, s[39 - 8 * i -: 8]);
    end
  endtask

  task automatic push(input logic [7:0] k);
    @(posedge clock);
    sampleValid <= 1'b1;
    sampleIn <= mk(k);
    @(posedge clock);
    sampleValid <= 1'b0;
  endtask

  task automatic tchg(input logic [11:0] v);
    @(posedge clock);
    tempChangeValid <= 1'b1;
    temp_change_value <= v;
    @(posedge clock);
    tempChangeValid <= 1'b0;
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    test_done();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    queueMode = QMODE_OFF;
    queue_threshold = 6'h02;
    wakeToActive = 1'b0;
    sampleValid = 1'b0;
    sampleIn = '0;
    tempChangeValid = 1'b0;
    temp_change_value = 12'h000;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    rd(8'h0c, ID);
    rs(8'h00);
    rd(8'h0e, 8'h00);
    rd(8'h20, 8'h00);
    // Disabled queue takes nothing, but live bytes follow the sample
    push(8'h05);
    rs(8'h00);
    rd(8'h02, 8'h5f);
    // Circular mode
    queueMode <= QMODE_CIRC;
    for (int k = 0; k < 3; k++) push(k[7:0]);
    rs(8'h43);
    rs(8'h43);
    rd(8'h02, 8'h00);
    rd(8'h05, 8'h00);
    tchg(12'hab5);
    rd(8'h0a, 8'hab);
    rd(8'h0b, 8'h50);
    rdb(8'h01, 8'h00, 0, 1);
    push(8'h03);
    rdb(8'h01, 8'h00, 2, 4);
    rs(8'h43);
    for (int k = 4; k <= 32; k++) push(k[7:0]);
    rs(8'h60);
    push(8'h21);
    rs(8'he0);
    rs(8'he0);
    rdb(8'h0e, 8'h02, 0, 4);
    rs(8'h5f);
    // Disable flushes
    queueMode <= QMODE_OFF;
    rs(8'h00);
    rd(8'h01, 8'h21);
    // Unused mode code behaves as disabled: nothing queued, live bytes readable
    queueMode <= QMODE_UNUSED;
    push(8'h09);
    rs(8'h00);
    rd(8'h03, 8'hf6);
    // Stop-when-full mode, threshold disabled
    queueMode <= QMODE_STOP;
    queue_threshold <= 6'h00;
    for (int k = 0; k <= 32; k++) push(k[7:0]);
    rs(8'ha0);
    rdb(8'h01, 8'h00, 0, 4);
    rs(8'h1f);
    tchg(12'h80f);
    rd(8'h0b, 8'hf0);
    @(posedge clock);
    wakeToActive <= 1'b1;
    @(posedge clock);
    wakeToActive <= 1'b0;
    rs(8'h00);
    push(8'h07);
    rdb(8'h01, 8'h07, 0, 4);
    rd(8'h01, 8'h00);
    rs(8'h00);
    test_done();
  end
endmodule // tb_sensor_sample_fifo_readout
